// ==== rtl/monitor_id_pkg.sv ====
// Shared constants for the monitor identity serial sender
package monitor_id_pkg;

  // ----------------------------------------------------------------
  // Identity record layout
  // ----------------------------------------------------------------
  localparam int unsigned RECORD_BYTES   = 128;
  localparam int unsigned RECORD_ADDR_W  = 7;
  localparam logic [6:0]  RECORD_LAST    = 7'h7F;
  localparam logic [63:0] RECORD_HEADER  = 64'h00FF_FFFF_FFFF_FF00;
  localparam logic [6:0]  HEADER_LAST    = 7'h07;
  localparam logic [7:0]  RECORD_FILL    = 8'h00;
  localparam logic [7:0]  RECORD_CHKSUM  = 8'h06;

  // ----------------------------------------------------------------
  // One-way stream framing: 8 data bits, MSB first, then a high bit
  // ----------------------------------------------------------------
  localparam logic [3:0]  SLOT_FIRST     = 4'h0;
  localparam logic [3:0]  SLOT_LAST      = 4'h8;
  localparam logic [2:0]  DATA_MSB       = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_PERIOD_PS = 4000;
  localparam int unsigned HSYNC_IDLE_US     = 1;
  localparam int unsigned VSYNC_IDLE_MS     = 100;
  localparam int unsigned HSYNC_IDLE_CYC    = (HSYNC_IDLE_US * 1000000) / SYS_CLK_PERIOD_PS;
  localparam int unsigned VSYNC_IDLE_CYC    = VSYNC_IDLE_MS * (1000000000 / SYS_CLK_PERIOD_PS);
  localparam int unsigned ACT_CNT_W         = 32;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_ON,
    PWR_STANDBY,
    PWR_SUSPEND,
    PWR_OFF
  } power_state_t;

  typedef enum logic [1:0] {
    ST_WAIT_SYNC,
    ST_STREAM,
    ST_IDLE
  } link_state_t;

endpackage : monitor_id_pkg

// ==== rtl/record_rom.sv ====
// Identity record store with registered read data
`timescale 1ns/1ps
`default_nettype none

module record_rom #(
  parameter int unsigned ADDR_W = monitor_id_pkg::RECORD_ADDR_W
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [7:0]        rd_data
);

  // ----------------------------------------------------------------
  // Record contents
  // ----------------------------------------------------------------
  function automatic logic [7:0] record_byte(input logic [ADDR_W-1:0] a);
    logic [5:0] sh;
    sh = 6'((7 - int'(a)) * 8);
    if (a <= ADDR_W'(monitor_id_pkg::HEADER_LAST)) begin
      record_byte = 8'(monitor_id_pkg::RECORD_HEADER >> sh);
    end else if (a == ADDR_W'(monitor_id_pkg::RECORD_LAST)) begin
      record_byte = monitor_id_pkg::RECORD_CHKSUM;
    end else begin
      record_byte = monitor_id_pkg::RECORD_FILL;
    end
  endfunction : record_byte

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= record_byte(rd_addr);
    end
  end

endmodule : record_rom

`default_nettype wire

// ==== rtl/monitor_id_serial_sender.sv ====
// Monitor-side identity record sender and power state detector
`timescale 1ns/1ps
`default_nettype none

module monitor_id_serial_sender #(
  parameter int unsigned HSYNC_IDLE_CYC = monitor_id_pkg::HSYNC_IDLE_CYC,
  parameter int unsigned VSYNC_IDLE_CYC = monitor_id_pkg::VSYNC_IDLE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        frame_sync_clock,
  input  wire logic        line_sync,
  input  wire logic        serial_clk_in,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  output logic             two_way_id_mode,
  output logic             one_way_id_mode,
  output logic [1:0]       display_power_signaling
);

  localparam int unsigned CW = monitor_id_pkg::ACT_CNT_W;

  typedef struct packed {
    logic [2:0]                  vs_sync;
    logic [2:0]                  hs_sync;
    logic [2:0]                  scl_sync;
    monitor_id_pkg::link_state_t st;
    logic [6:0]                  byte_idx;
    logic [3:0]                  bit_idx;
    logic                        data_oe;
    logic [CW-1:0]               hs_cnt;
    logic [CW-1:0]               vs_cnt;
    monitor_id_pkg::power_state_t pwr;
  } state_t;

  localparam state_t RESET_STATE = '{
    vs_sync:  3'h0,
    hs_sync:  3'h0,
    scl_sync: 3'h7,
    st:       monitor_id_pkg::ST_WAIT_SYNC,
    byte_idx: 7'h00,
    bit_idx:  monitor_id_pkg::SLOT_FIRST,
    data_oe:  1'b0,
    hs_cnt:   '0,
    vs_cnt:   '0,
    pwr:      monitor_id_pkg::PWR_ON
  };

  state_t     cur_ff;
  state_t     nxt_state;
  logic [7:0] rom_data;
  logic       vs_rise;
  logic       hs_rise;
  logic       scl_fall;
  logic       out_bit;
  logic       hs_active;
  logic       vs_active;

  // ----------------------------------------------------------------
  // Record store
  // ----------------------------------------------------------------
  record_rom #(
    .ADDR_W (monitor_id_pkg::RECORD_ADDR_W)
  ) u_rom (
    .sys_clk (sys_clk),
    .rst     (rst),
    .rd_addr (cur_ff.byte_idx),
    .rd_data (rom_data)
  );

  // ----------------------------------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------------------------------
  assign vs_rise   = cur_ff.vs_sync[1] & ~cur_ff.vs_sync[2];
  assign hs_rise   = cur_ff.hs_sync[1] & ~cur_ff.hs_sync[2];
  assign scl_fall  = ~cur_ff.scl_sync[1] & cur_ff.scl_sync[2];
  assign hs_active = cur_ff.hs_cnt < CW'(HSYNC_IDLE_CYC);
  assign vs_active = cur_ff.vs_cnt < CW'(VSYNC_IDLE_CYC);

  // Current bit: data MSB first, then a high framing bit
  assign out_bit = (cur_ff.bit_idx == monitor_id_pkg::SLOT_LAST) ? 1'b1 :
                   rom_data[3'(monitor_id_pkg::DATA_MSB - cur_ff.bit_idx[2:0])];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state          = cur_ff;
    nxt_state.vs_sync  = {cur_ff.vs_sync[1:0], frame_sync_clock};
    nxt_state.hs_sync  = {cur_ff.hs_sync[1:0], line_sync};
    nxt_state.scl_sync = {cur_ff.scl_sync[1:0], serial_clk_in};

    case (cur_ff.st)
      monitor_id_pkg::ST_WAIT_SYNC: begin
        if (scl_fall) begin
          nxt_state.st      = monitor_id_pkg::ST_IDLE;
          nxt_state.data_oe = 1'b0;
        end else if (vs_rise) begin
          nxt_state.st      = monitor_id_pkg::ST_STREAM;
          nxt_state.data_oe = ~out_bit;
          nxt_state.bit_idx = cur_ff.bit_idx + 4'h1;
        end
      end
      monitor_id_pkg::ST_STREAM: begin
        if (scl_fall) begin
          nxt_state.st      = monitor_id_pkg::ST_IDLE;
          nxt_state.data_oe = 1'b0;
        end else if (vs_rise) begin
          nxt_state.data_oe = ~out_bit;
          if (cur_ff.bit_idx == monitor_id_pkg::SLOT_LAST) begin
            nxt_state.bit_idx  = monitor_id_pkg::SLOT_FIRST;
            nxt_state.byte_idx = cur_ff.byte_idx + 7'h01;
          end else begin
            nxt_state.bit_idx  = cur_ff.bit_idx + 4'h1;
          end
        end
      end
      monitor_id_pkg::ST_IDLE: begin
        nxt_state.data_oe = 1'b0;
      end
      default: begin
        nxt_state.st      = monitor_id_pkg::ST_IDLE;
        nxt_state.data_oe = 1'b0;
      end
    endcase

    // Sync activity counters for power state decode
    if (hs_rise) begin
      nxt_state.hs_cnt = '0;
    end else if (hs_active) begin
      nxt_state.hs_cnt = cur_ff.hs_cnt + CW'(1);
    end
    if (vs_rise) begin
      nxt_state.vs_cnt = '0;
    end else if (vs_active) begin
      nxt_state.vs_cnt = cur_ff.vs_cnt + CW'(1);
    end

    if (hs_active && vs_active) begin
      nxt_state.pwr = monitor_id_pkg::PWR_ON;
    end else if (vs_active) begin
      nxt_state.pwr = monitor_id_pkg::PWR_STANDBY;
    end else if (hs_active) begin
      nxt_state.pwr = monitor_id_pkg::PWR_SUSPEND;
    end else begin
      nxt_state.pwr = monitor_id_pkg::PWR_OFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur_ff <= RESET_STATE;
    end else begin
      cur_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_data_out         = 1'b0;
  assign serial_data_oe          = cur_ff.data_oe;
  assign one_way_id_mode         = (cur_ff.st == monitor_id_pkg::ST_STREAM);
  assign two_way_id_mode         = (cur_ff.st == monitor_id_pkg::ST_IDLE);
  assign display_power_signaling = cur_ff.pwr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_start_on_sync: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_ff.st == monitor_id_pkg::ST_WAIT_SYNC && vs_rise && !scl_fall) |=> one_way_id_mode)
    else $error("stream did not start on first frame sync");

  a_quiet_before_sync: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_ff.st == monitor_id_pkg::ST_WAIT_SYNC) |-> !serial_data_oe)
    else $error("data driven before first frame sync");

  a_stream_holds: assert property (@(posedge sys_clk) disable iff (rst)
    (one_way_id_mode && !scl_fall) |=> one_way_id_mode)
    else $error("stream stopped without clock fall");

  a_idle_on_fall: assert property (@(posedge sys_clk) disable iff (rst)
    (one_way_id_mode && scl_fall) |=> (two_way_id_mode && !serial_data_oe) [*3])
    else $error("clock fall did not idle the sender");

  a_header_first: assert property (@(posedge sys_clk) disable iff (rst)
    (one_way_id_mode && vs_rise && !scl_fall && cur_ff.byte_idx == 7'h01 &&
     cur_ff.bit_idx == 4'h3) |=> !serial_data_oe)
    else $error("header byte bit not released high");

  a_bit_per_sync: assert property (@(posedge sys_clk) disable iff (rst)
    (one_way_id_mode && !vs_rise && !scl_fall) |=> $stable(cur_ff.bit_idx) && $stable(serial_data_oe))
    else $error("stream moved without frame sync");

  a_record_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    (one_way_id_mode && vs_rise && !scl_fall && cur_ff.byte_idx == monitor_id_pkg::RECORD_LAST &&
     cur_ff.bit_idx == monitor_id_pkg::SLOT_LAST) |=> (cur_ff.byte_idx == 7'h00 && cur_ff.bit_idx == 4'h0))
    else $error("record did not wrap");

  a_power_off: assert property (@(posedge sys_clk) disable iff (rst)
    (!hs_active && !vs_active) [*2] |-> display_power_signaling == monitor_id_pkg::PWR_OFF)
    else $error("no sync activity but power not off");

  a_power_on: assert property (@(posedge sys_clk) disable iff (rst)
    (hs_active && vs_active) |=> display_power_signaling == monitor_id_pkg::PWR_ON)
    else $error("both syncs active but power not on");

endmodule : monitor_id_serial_sender

`default_nettype wire

// ==== tb/adapter_model.sv ====
// Display adapter model driving the sync and serial clock lines
`timescale 1ns/1ps
`default_nettype none

module adapter_model (
  input  wire logic data_wire,
  output logic      frame_sync_clock,
  output logic      line_sync,
  output logic      serial_clk_in
);
  logic hs_on;
  logic clk_low;

  initial begin
    frame_sync_clock = 1'b0;
    line_sync = 1'b0;
    hs_on = 1'b0;
    clk_low = 1'b0;
  end

  // Pulled-up clock wire, only ever pulled low
  assign serial_clk_in = clk_low ? 1'b0 : 1'b1;

  always begin
    #40;
    line_sync = hs_on ? ~line_sync : 1'b0;
  end

  // Frame sync slots at 48 ns, wire read before the next rise, still between calls
  task automatic frame_slots(input int n, output logic [8:0] bits);
    bits = 9'h1FF;
    #1.3;
    for (int i = 0; i < n; i++) begin
      frame_sync_clock = 1'b1;
      #24;
      frame_sync_clock = 1'b0;
      bits = {bits[7:0], data_wire};
      #24;
    end
  endtask : frame_slots
endmodule : adapter_model

`default_nettype wire

// ==== tb/tb_monitor_id_serial_sender.sv ====
// Self-checking bench for the monitor identity serial sender
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
  end \
end

module tb_monitor_id_serial_sender;
  logic       sys_clk;
  logic       rst;
  logic       frame_sync_clock;
  logic       line_sync;
  logic       serial_clk_in;
  logic       data_wire;
  logic       serial_data_out;
  logic       serial_data_oe;
  logic       two_way_id_mode;
  logic       one_way_id_mode;
  logic [1:0] display_power_signaling;
  int         num_errors;
  int         compares;
  int         cycles;
  logic [8:0] bits;
  logic [7:0] sum;

  // Open-drain data wire with pull-up
  assign data_wire = serial_data_oe ? serial_data_out : 1'b1;

  monitor_id_serial_sender #(.HSYNC_IDLE_CYC(200), .VSYNC_IDLE_CYC(400)) u_monitor_id_serial_sender (
    .sys_clk(sys_clk), .rst(rst), .frame_sync_clock(frame_sync_clock), .line_sync(line_sync),
    .serial_clk_in(serial_clk_in), .serial_data_in(data_wire), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .two_way_id_mode(two_way_id_mode),
    .one_way_id_mode(one_way_id_mode), .display_power_signaling(display_power_signaling));

  adapter_model u_adapter_model (.data_wire(data_wire), .frame_sync_clock(frame_sync_clock),
    .line_sync(line_sync), .serial_clk_in(serial_clk_in));

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_byte(input int i);
    if (i < 8) return monitor_id_pkg::RECORD_HEADER[63 - 8 * i -: 8];
    if (i == 127) return monitor_id_pkg::RECORD_CHKSUM;
    return monitor_id_pkg::RECORD_FILL;
  endfunction : exp_byte

  task do_reset;
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
  endtask : do_reset

  task check_reset;
    repeat (20) @(negedge sys_clk);
    `CHECK({serial_data_oe, one_way_id_mode, two_way_id_mode, serial_data_out}, 4'h0)
    `CHECK(display_power_signaling, 2'h0)
  endtask : check_reset

  task stream_record;
    u_adapter_model.hs_on = 1'b1;
    sum = 8'h00;
    for (int b = 0; b < 129; b++) begin
      u_adapter_model.frame_slots(9, bits);
      `CHECK(bits, {exp_byte(b % 128), 1'b1})
      if (b < 128) sum = sum + bits[8:1];
    end
    `CHECK(sum, 8'h00)
    `CHECK({one_way_id_mode, two_way_id_mode}, 2'h2)
  endtask : stream_record

  task power_states;
    for (int k = 3; k >= 0; k--) begin
      u_adapter_model.hs_on = k[0];
      if (k[1]) u_adapter_model.frame_slots(60, bits);
      else repeat (600) @(negedge sys_clk);
      @(negedge sys_clk);
      `CHECK(display_power_signaling, 2'(3 - k))
    end
  endtask : power_states

  task clock_fall;
    @(negedge sys_clk);
    u_adapter_model.clk_low = 1'b1;
    repeat (6) @(negedge sys_clk);
    `CHECK({two_way_id_mode, one_way_id_mode, serial_data_oe}, 3'h4)
    u_adapter_model.frame_slots(18, bits);
    `CHECK(bits, 9'h1FF)
    `CHECK(one_way_id_mode, 1'b0)
  endtask : clock_fall

  task early_fall;
    u_adapter_model.clk_low = 1'b0;
    do_reset();
    repeat (6) @(negedge sys_clk);
    u_adapter_model.clk_low = 1'b1;
    repeat (6) @(negedge sys_clk);
    `CHECK(two_way_id_mode, 1'b1)
    u_adapter_model.frame_slots(9, bits);
    `CHECK({bits, one_way_id_mode}, 10'h3FE)
    u_adapter_model.clk_low = 1'b0;
    do_reset();
    repeat (6) @(negedge sys_clk);
    u_adapter_model.frame_slots(9, bits);
    `CHECK(bits, 9'h001)
  endtask : early_fall

  task results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  initial begin
    rst = 1'b1;
    num_errors = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    check_reset();
    stream_record();
    power_states();
    clock_fall();
    early_fall();
    results();
  end
endmodule : tb_monitor_id_serial_sender

`default_nettype wire
